// ==== common/gfx_pkg.sv ====
`default_nettype none
package gfx_pkg;
  // Register map, one aligned word each; R0..at 4*n
  localparam logic [7:0] OFF_R0 = 8'h00;
  localparam logic [7:0] OFF_WIDTH = 8'h20;
  localparam logic [7:0] OFF_CMD = 8'h24;
  localparam logic [7:0] OFF_PSW = 8'h28;
  localparam logic [7:0] OFF_STAT = 8'h2C;
  localparam int IDX_HI = 4;
  localparam int IDX_LO = 2;
  localparam int PSW_F = 0;
  localparam int PSW_L = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  // Instruction word fields
  localparam logic [7:0] ENC_BB = 8'h0E;
  localparam logic [7:0] ENC_WORD_OR = 8'h2E;
  localparam logic [7:0] ENC_COPRO = 8'h4E;
  localparam logic [7:0] ENC_PATTERN = 8'h6E;
  localparam logic [7:0] ENC_BITTEST = 8'h8E;
  localparam int ZERO_HI = 23;
  localparam int ZERO_LO = 19;
  localparam int BIT_D = 18;
  localparam int BIT_X = 17;
  localparam int BIT_S = 15;
  localparam int OP_HI = 14;
  localparam int OP_LO = 11;
  localparam int SZ_HI = 10;
  localparam int SZ_LO = 9;
  localparam logic [3:0] OP_AND = 4'hA;
  localparam logic [3:0] OP_OR = 4'h6;
  localparam logic [3:0] OP_XOR = 4'hE;
  localparam logic [3:0] OP_FOR = 4'hC;
  localparam logic [3:0] OP_COPY = 4'h4;
  localparam logic [1:0] SZ_AND = 2'h3;
  localparam logic [1:0] SZ_OTHER = 2'h1;
  // Memory cycle kinds
  localparam logic [1:0] CYC_SRC_RD = 2'h0;
  localparam logic [1:0] CYC_DST_RD = 2'h1;
  localparam logic [1:0] CYC_DST_WR = 2'h2;
  localparam logic [31:0] WORD_BYTES = 32'h2;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_LINE = 4'h1, ST_SRC = 4'h3, ST_DST = 4'h2,
    ST_WR = 4'h6, ST_STEP = 4'h7, ST_PRE = 4'h5
  } state_t;
  typedef enum logic [2:0] {
    K_AND, K_OR, K_XOR, K_COPY, K_WORD_OR, K_COPRO, K_PATTERN, K_BITTEST
  } kind_t;
endpackage
`default_nettype wire

// ==== core/gfx_exec.sv ====
// Overview of operation
// - Masked moves: AND, OR, XOR, fast OR, copy
// - Ascending and true source are defaults
// - Fast OR: only ascending, true source
// - Edge masks follow source word order
// - Width counts source words per line
// - Horizontal by option, vertical by warp sign
// - Encoding: zero bits, D, S, X fields
// - Op and size fields decoded per table
// - Word OR: shift left, OR, step two
// - Coprocessor move repeats read/read/write cycles
// - Coprocessor step sign, final register values
// - Extra line-start source read unless L
// - Pattern stored count times, pointer stepped
// - Pattern end: count zero, last address
// - Bit test counts run from offset
// - Bit test keeps base, limits; updates offset
// - F takes value of previous bit
// - Offset past maximum: F equals option
// - L set on found bit or limit
// - Select bit gives bit test option
`default_nettype none
module gfx_exec
  import gfx_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Memory bus master
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [23:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output logic [1:0] MEM_CYCLE,
  output logic MEM_COPRO,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_ACK
);
  state_t state_q;
  kind_t kind_q, cmd_kind;
  logic [31:0] gpr_q [8];
  logic [31:0] width_q, wcnt_q, line_words;
  logic [15:0] src_q, prev_q, res_q, srcv, mask, opres, wres;
  logic [31:0] shl, shr, wide, hstep, bt_addr;
  logic desc_q, inv_q, opt_q, first_q, half_q, flag_f_q, flag_l_q;
  logic err_q, armed_q, acc, is_bb, wr_en, cmd_wr, cmd_ok, bus_st;
  logic [31:0] prdata_q;
  logic [23:0] addr_q;
  logic [15:0] wdata_q;
  logic [1:0] cyc_q;
  logic we_q, copro_q;
  logic [3:0] op_f;
  logic mapped;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  assign op_f = PWDATA[OP_HI:OP_LO];
  assign acc = armed_q && MEM_ACK;
  assign is_bb = !kind_q[2];
  assign bus_st = state_q inside {ST_SRC, ST_DST, ST_WR, ST_PRE};
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign cmd_wr = wr_en && PADDR == OFF_CMD && state_q == ST_IDLE;
  assign mapped = PADDR <= OFF_STAT && PADDR[1:0] == '0;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = prdata_q;
  assign MEM_REQ = armed_q;
  assign MEM_WE = we_q;
  assign MEM_ADDR = addr_q;
  assign MEM_WDATA = wdata_q;
  assign MEM_CYCLE = cyc_q;
  assign MEM_COPRO = copro_q;

  // Instruction word decode
  always_comb begin
    cmd_kind = K_AND;
    cmd_ok = 1'b0;
    case (PWDATA[7:0])
      ENC_BB: begin
        cmd_ok = PWDATA[ZERO_HI:ZERO_LO] == '0 &&
          PWDATA[BIT_X] == (op_f == OP_AND) &&
          PWDATA[SZ_HI:SZ_LO] == (op_f == OP_AND ? SZ_AND : SZ_OTHER);
        case (op_f)
          OP_AND: cmd_kind = K_AND;
          OP_OR: cmd_kind = K_OR;
          OP_XOR: cmd_kind = K_XOR;
          OP_COPY: cmd_kind = K_COPY;
          OP_FOR: begin
            cmd_kind = K_OR;
            if (PWDATA[BIT_D] || PWDATA[BIT_S]) begin
              cmd_ok = 1'b0;
            end
          end
          default: cmd_ok = 1'b0;
        endcase
      end
      ENC_WORD_OR: begin
        cmd_kind = K_WORD_OR;
        cmd_ok = 1'b1;
      end
      ENC_COPRO: begin
        cmd_kind = K_COPRO;
        cmd_ok = 1'b1;
      end
      ENC_PATTERN: begin
        cmd_kind = K_PATTERN;
        cmd_ok = 1'b1;
      end
      ENC_BITTEST: begin
        cmd_kind = K_BITTEST;
        cmd_ok = 1'b1;
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  // Data path for one destination word
  always_comb begin
    shl = {src_q, prev_q} << gpr_q[2][3:0];
    shr = {prev_q, src_q} >> gpr_q[2][3:0];
    srcv = desc_q ? shr[15:0] : shl[31:16];
    if (inv_q) begin
      srcv = ~srcv;
    end
    mask = ALL_ONES;
    if (first_q) begin
      mask = mask & gpr_q[4][15:0];
    end
    if (wcnt_q == 32'h1) begin
      mask = mask & gpr_q[5][15:0];
    end
    case (kind_q)
      K_AND: opres = srcv & MEM_RDATA;
      K_OR: opres = srcv | MEM_RDATA;
      K_XOR: opres = srcv ^ MEM_RDATA;
      default: opres = srcv;
    endcase
    wres = (opres & mask) | (MEM_RDATA & ~mask);
    wide = {16'h0, src_q} << gpr_q[2][3:0];
    hstep = kind_q == K_COPRO ? gpr_q[4] :
      (desc_q ? -WORD_BYTES : WORD_BYTES);
    bt_addr = gpr_q[0] + 32'($signed(gpr_q[1]) >>> 3);
    line_words = kind_q == K_COPRO ? (gpr_q[2] + 32'h1) >> 1 : width_q;
  end

  // Execution sequencer and operand registers
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      for (int i = 0; i < 8; i++) begin
        gpr_q[i] <= '0;
      end
      width_q <= '0;
      wcnt_q <= '0;
      kind_q <= K_AND;
      desc_q <= 1'b0;
      inv_q <= 1'b0;
      opt_q <= 1'b0;
      first_q <= 1'b0;
      half_q <= 1'b0;
      src_q <= '0;
      prev_q <= '0;
      res_q <= '0;
      flag_f_q <= 1'b0;
      flag_l_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_en && PADDR < OFF_WIDTH) begin
            gpr_q[PADDR[IDX_HI:IDX_LO]] <= PWDATA;
          end
          if (wr_en && PADDR == OFF_WIDTH) begin
            width_q <= PWDATA;
          end
          if (wr_en && PADDR == OFF_PSW) begin
            flag_f_q <= PWDATA[PSW_F];
            flag_l_q <= PWDATA[PSW_L];
          end
          if (cmd_wr) begin
            err_q <= !cmd_ok;
          end
          if (cmd_wr && cmd_ok) begin
            kind_q <= cmd_kind;
            desc_q <= PWDATA[7:0] == ENC_BB && PWDATA[BIT_D];
            inv_q <= PWDATA[7:0] == ENC_BB && PWDATA[BIT_S];
            opt_q <= PWDATA[BIT_S];
            half_q <= 1'b0;
            res_q <= gpr_q[3][15:0];
            case (cmd_kind)
              K_WORD_OR: state_q <= ST_SRC;
              K_PATTERN: state_q <= gpr_q[2] == '0 ? ST_IDLE : ST_WR;
              K_BITTEST: begin
                gpr_q[2] <= '0;
                flag_f_q <= PWDATA[BIT_S];
                state_q <= ST_STEP;
              end
              default: state_q <= ST_LINE;
            endcase
          end
        end
        ST_LINE: begin
          if (gpr_q[3] == '0 || line_words == '0) begin
            state_q <= ST_IDLE;
          end else begin
            wcnt_q <= line_words;
            first_q <= 1'b1;
            prev_q <= '0;
            if (kind_q == K_COPRO) begin
              gpr_q[5] <= line_words;
            end
            state_q <= kind_q == K_COPRO && !flag_l_q ? ST_PRE : ST_SRC;
          end
        end
        ST_PRE: begin
          if (acc) begin
            prev_q <= MEM_RDATA;
            state_q <= ST_SRC;
          end
        end
        ST_SRC: begin
          if (acc && kind_q == K_BITTEST) begin
            if (MEM_RDATA[gpr_q[1][2:0]] == opt_q) begin
              gpr_q[1] <= gpr_q[1] + 32'h1;
              gpr_q[2] <= gpr_q[2] + 32'h1;
              state_q <= ST_STEP;
            end else begin
              flag_l_q <= 1'b1;
              state_q <= ST_IDLE;
            end
          end else if (acc) begin
            src_q <= MEM_RDATA;
            state_q <= ST_DST;
          end
        end
        ST_DST: begin
          if (acc) begin
            case (kind_q)
              K_WORD_OR: res_q <= MEM_RDATA |
                (half_q ? wide[31:16] : wide[15:0]);
              K_COPRO: res_q <= '0;
              default: res_q <= wres;
            endcase
            state_q <= ST_WR;
          end
        end
        ST_WR: begin
          if (acc) begin
            case (kind_q)
              K_WORD_OR: begin
                half_q <= 1'b1;
                state_q <= half_q ? ST_IDLE : ST_DST;
                if (half_q) begin
                  gpr_q[0] <= gpr_q[0] + WORD_BYTES;
                  gpr_q[1] <= gpr_q[1] + WORD_BYTES;
                end
              end
              K_PATTERN: begin
                gpr_q[2] <= gpr_q[2] - 32'h1;
                if (gpr_q[2] == 32'h1) begin
                  state_q <= ST_IDLE;
                end else begin
                  gpr_q[0] <= gpr_q[0] + gpr_q[1];
                end
              end
              default: begin
                if (kind_q == K_COPRO) begin
                  gpr_q[5] <= wcnt_q - 32'h1;
                end
                if (wcnt_q == 32'h1) begin
                  gpr_q[0] <= gpr_q[0] + gpr_q[6];
                  gpr_q[1] <= gpr_q[1] + gpr_q[7];
                  gpr_q[3] <= gpr_q[3] - 32'h1;
                  state_q <= ST_LINE;
                end else begin
                  gpr_q[0] <= gpr_q[0] + hstep;
                  gpr_q[1] <= gpr_q[1] + hstep;
                  wcnt_q <= wcnt_q - 32'h1;
                  first_q <= 1'b0;
                  prev_q <= src_q;
                  state_q <= ST_SRC;
                end
              end
            endcase
          end
        end
        ST_STEP: begin
          if (gpr_q[2] == gpr_q[3]) begin
            flag_l_q <= 1'b1;
            state_q <= ST_IDLE;
          end else if ($signed(gpr_q[1]) >= $signed(gpr_q[4])) begin
            flag_l_q <= 1'b0;
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_SRC;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Memory bus cycle outputs
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      armed_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      cyc_q <= CYC_SRC_RD;
      we_q <= 1'b0;
      copro_q <= 1'b0;
    end else begin
      armed_q <= bus_st && !acc;
      copro_q <= kind_q == K_COPRO && state_q != ST_IDLE;
      case (state_q)
        ST_SRC, ST_PRE: begin
          addr_q <= kind_q == K_BITTEST ? bt_addr[23:0] : gpr_q[0][23:0];
          cyc_q <= CYC_SRC_RD;
          we_q <= 1'b0;
        end
        ST_DST: begin
          addr_q <= 24'(gpr_q[1] + (half_q ? WORD_BYTES : '0));
          cyc_q <= CYC_DST_RD;
          we_q <= 1'b0;
        end
        ST_WR: begin
          addr_q <= kind_q == K_PATTERN ? gpr_q[0][23:0] :
            24'(gpr_q[1] + (half_q ? WORD_BYTES : '0));
          wdata_q <= res_q;
          cyc_q <= CYC_DST_WR;
          we_q <= 1'b1;
        end
        default: we_q <= 1'b0;
      endcase
    end
  end

  // APB read data, latched in the setup cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      prdata_q <= '0;
    end else if (PSEL && !PENABLE) begin
      prdata_q <= '0;
      if (PADDR < OFF_WIDTH) begin
        prdata_q <= gpr_q[PADDR[IDX_HI:IDX_LO]];
      end
      case (PADDR)
        OFF_WIDTH: prdata_q <= width_q;
        OFF_PSW: begin
          prdata_q[PSW_F] <= flag_f_q;
          prdata_q[PSW_L] <= flag_l_q;
        end
        OFF_STAT: begin
          prdata_q[STAT_BUSY] <= state_q != ST_IDLE;
          prdata_q[STAT_ERR] <= err_q;
        end
        default: ;
      endcase
    end
  end

  a_bus_hold:
    assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("memory request dropped before acknowledge");
  a_fastor_reject:
    assert property (cmd_wr && PWDATA[7:0] == ENC_BB && op_f == OP_FOR &&
      (PWDATA[BIT_D] || PWDATA[BIT_S]) |=> state_q == ST_IDLE && err_q)
    else $error("fast OR accepted an illegal option");
  a_word_or_step:
    assert property (kind_q == K_WORD_OR && state_q == ST_WR && half_q &&
      acc |=> gpr_q[0] == $past(gpr_q[0]) + WORD_BYTES &&
      state_q == ST_IDLE)
    else $error("word OR pointer step wrong");
  a_pattern_count:
    assert property (kind_q == K_PATTERN && state_q == ST_WR && acc |=>
      gpr_q[2] == $past(gpr_q[2]) - 32'h1)
    else $error("pattern count not decremented");
  a_pattern_end:
    assert property (kind_q == K_PATTERN && state_q == ST_WR && acc &&
      gpr_q[2] == 32'h1 |=> state_q == ST_IDLE && gpr_q[2] == '0 &&
      $stable(gpr_q[0]))
    else $error("pattern end state wrong");
  a_line_end:
    assert property (is_bb && state_q == ST_WR && acc && wcnt_q == 32'h1
      |=> state_q == ST_LINE && gpr_q[3] == $past(gpr_q[3]) - 32'h1)
    else $error("scan line end not taken");
  a_desc_step:
    assert property (is_bb && desc_q && state_q == ST_WR && acc &&
      wcnt_q != 32'h1 |=> gpr_q[0] == $past(gpr_q[0]) - WORD_BYTES)
    else $error("descending step wrong");
  a_copro_preload:
    assert property (state_q == ST_LINE && kind_q == K_COPRO &&
      gpr_q[3] != '0 && line_words != '0 |=>
      state_q == ($past(flag_l_q) ? ST_SRC : ST_PRE))
    else $error("extra source read choice wrong");
  a_bt_keep:
    assert property (kind_q == K_BITTEST && state_q != ST_IDLE |=>
      $stable(gpr_q[0]) && $stable(gpr_q[3]) && $stable(gpr_q[4]))
    else $error("bit test altered a fixed register");
  a_bt_flag:
    assert property (kind_q == K_BITTEST && state_q != ST_IDLE ##1
      state_q == ST_IDLE |-> flag_f_q == opt_q)
    else $error("bit test F flag wrong");
endmodule
`default_nettype wire

// ==== tb/bitblt_graphics_instr_unit_tb_top.sv ====
`default_nettype none
module bitblt_graphics_instr_unit_tb_top
  import gfx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic PREADY, PSLVERR, MEM_REQ, MEM_WE, MEM_COPRO, MEM_ACK, e;
  logic slow = 0;
  logic [23:0] MEM_ADDR;
  logic [15:0] MEM_WDATA, MEM_RDATA;
  logic [1:0] MEM_CYCLE;
  int mismatches = 0, checks = 0;
  logic [3:0] ops [5] = '{OP_AND, OP_OR, OP_XOR, OP_FOR, OP_COPY};

  gfx_exec gfx_exec_inst (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ),
    .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_CYCLE(MEM_CYCLE), .MEM_COPRO(MEM_COPRO), .MEM_RDATA(MEM_RDATA),
    .MEM_ACK(MEM_ACK));
  mem_partner mem_partner_inst (.clk(CORE_CLK), .rstn(RSTN), .slow(slow),
    .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA),
    .cycle(MEM_CYCLE), .copro(MEM_COPRO), .rdata(MEM_RDATA), .ack(MEM_ACK));

  initial begin
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  task complete_run;
    $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      check("pready timeout", 0, 1);
      complete_run();
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task wreg(input int i, input logic [31:0] v);
    apb(1'b1, OFF_R0 + 8'(4 * i), v);
  endtask

  task xreg(input int i, input logic [31:0] v, input string what);
    apb(1'b0, OFF_R0 + 8'(4 * i), 32'h0);
    check(what, q, v);
  endtask

  task run(input logic [31:0] cmd);
    int n;
    apb(1'b1, OFF_CMD, cmd);
    n = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 300);
    if (n >= 300) begin
      check("busy timeout", 0, 1);
      complete_run();
    end
  endtask

  task poke(input logic [7:0] a, input logic [15:0] v);
    mem_partner_inst.mem[a] = v[7:0];
    mem_partner_inst.mem[a + 8'h01] = v[15:8];
  endtask

  function automatic logic [15:0] peek(input logic [7:0] a);
    return {mem_partner_inst.mem[a + 8'h01], mem_partner_inst.mem[a]};
  endfunction

  task test_map;
    apb(1'b0, OFF_STAT, 32'h0);
    check("stat reset", q, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check("unmapped err", 32'(e), 32'h1);
    $display("test_map done");
  endtask

  task test_pattern;
    slow <= 1'b1;
    poke(8'h0A, 16'h0000);
    wreg(0, 32'h10);
    wreg(1, 32'hFFFF_FFFE);
    wreg(2, 32'h3);
    wreg(3, 32'h1234_A5C3);
    run({24'h0, ENC_PATTERN});
    check("pat 10", 32'(peek(8'h10)), 32'hA5C3);
    check("pat 0E", 32'(peek(8'h0E)), 32'hA5C3);
    check("pat 0C", 32'(peek(8'h0C)), 32'hA5C3);
    check("pat 0A", 32'(peek(8'h0A)), 32'h0);
    xreg(0, 32'h0C, "pat dest");
    xreg(1, 32'hFFFF_FFFE, "pat incr");
    xreg(2, 32'h0, "pat count");
    xreg(3, 32'h1234_A5C3, "pat value");
    slow <= 1'b0;
    $display("test_pattern done");
  endtask

  task test_word_or;
    poke(8'h40, 16'h8001);
    poke(8'h50, 16'h0F00);
    poke(8'h52, 16'h0000);
    wreg(0, 32'h40);
    wreg(1, 32'h50);
    wreg(2, 32'h4);
    run({24'h0, ENC_WORD_OR});
    check("wor low", 32'(peek(8'h50)), 32'h0F10);
    check("wor high", 32'(peek(8'h52)), 32'h0008);
    xreg(0, 32'h42, "wor src");
    xreg(1, 32'h52, "wor dst");
    $display("test_word_or done");
  endtask

  task bit_case(input logic opt, input logic [31:0] r1, r3, x1, x2,
                input logic f, l);
    wreg(0, 32'h60);
    wreg(1, r1);
    wreg(2, 32'h0);
    wreg(3, r3);
    wreg(4, 32'd16);
    run({16'h0, opt, 7'h0, ENC_BITTEST});
    xreg(1, x1, "bt offset");
    xreg(2, x2, "bt run");
    xreg(0, 32'h60, "bt base");
    xreg(3, r3, "bt limit");
    xreg(4, 32'd16, "bt max");
    apb(1'b0, OFF_PSW, 32'h0);
    check("bt F", 32'(q[PSW_F]), 32'(f));
    check("bt L", 32'(q[PSW_L]), 32'(l));
  endtask

  task test_bit_test;
    poke(8'h60, 16'h000F);
    bit_case(1'b1, 0, 20, 4, 4, 1'b1, 1'b1);
    bit_case(1'b0, 4, 20, 16, 12, 1'b0, 1'b0);
    bit_case(1'b1, 0, 2, 2, 2, 1'b1, 1'b1);
    bit_case(1'b1, 20, 20, 20, 0, 1'b1, 1'b0);
    bit_case(1'b0, 20, 20, 20, 0, 1'b0, 1'b0);
    $display("test_bit_test done");
  endtask

  function automatic logic [15:0] comb(input logic [3:0] op,
      input logic [15:0] s, d);
    case (op)
      OP_AND: return s & d;
      OP_XOR: return s ^ d;
      OP_COPY: return s;
      default: return s | d;
    endcase
  endfunction

  task bb_case(input logic [3:0] op, input logic s, d,
               input logic [15:0] m);
    logic bad;
    logic [15:0] s0, s1;
    bad = (op == OP_FOR) && (s || d);
    s0 = s ? 16'hCCAA : 16'h3355;
    s1 = s ? 16'h3C5A : 16'hC3A5;
    poke(8'h80, 16'h3355);
    poke(8'h84, 16'hC3A5);
    poke(8'hA0, 16'h0F0F);
    poke(8'hA4, 16'h0F0F);
    wreg(0, 32'h80);
    wreg(1, 32'hA0);
    wreg(2, 32'h0);
    wreg(3, 32'h2);
    wreg(4, 32'(m));
    wreg(5, 32'hFFFF);
    wreg(6, 32'h4);
    wreg(7, 32'h4);
    apb(1'b1, OFF_WIDTH, 32'h1);
    run({13'h0, d, op == OP_AND, 1'b0, s, op,
         op == OP_AND ? SZ_AND : SZ_OTHER, 1'b0, ENC_BB});
    apb(1'b0, OFF_STAT, 32'h0);
    check("bb err", 32'(q[STAT_ERR]), 32'(bad));
    check("bb line0", 32'(peek(8'hA0)), bad ? 32'h0F0F :
          32'((comb(op, s0, 16'h0F0F) & m) | (16'h0F0F & ~m)));
    check("bb line1", 32'(peek(8'hA4)), bad ? 32'h0F0F :
          32'((comb(op, s1, 16'h0F0F) & m) | (16'h0F0F & ~m)));
  endtask

  task test_masked;
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 4; k++) begin
        bb_case(ops[i], k[0], k[1], 16'hFFFF);
      end
    end
    bb_case(OP_COPY, 1'b0, 1'b0, 16'h0FF0);
    $display("test_masked done");
  endtask

  // Two-word descending copy: step back one word, masks per word
  task test_desc;
    poke(8'h80, 16'h1234);
    poke(8'h82, 16'h5678);
    poke(8'hA0, 16'h0000);
    poke(8'hA2, 16'h0000);
    wreg(0, 32'h82);
    wreg(1, 32'hA2);
    wreg(2, 32'h0);
    wreg(3, 32'h1);
    wreg(4, 32'h00FF);
    wreg(5, 32'hFF00);
    wreg(6, 32'h10);
    wreg(7, 32'h10);
    apb(1'b1, OFF_WIDTH, 32'h2);
    run({13'h0, 1'b1, 1'b0, 1'b0, 1'b0, OP_COPY, SZ_OTHER, 1'b0, ENC_BB});
    check("desc first", 32'(peek(8'hA2)), 32'h0078);
    check("desc last", 32'(peek(8'hA0)), 32'h1200);
    xreg(0, 32'h90, "desc src");
    xreg(1, 32'hB0, "desc dst");
    xreg(3, 32'h0, "desc height");
    $display("test_desc done");
  endtask

  task test_copro;
    int n0;
    mem_partner_inst.copro_ctrl = 16'hBEEF;
    for (int l = 0; l < 2; l++) begin
      poke(8'hA0, 16'h0000);
      wreg(0, 32'h80);
      wreg(1, 32'hA0);
      wreg(2, 32'h2);
      wreg(3, 32'h1);
      wreg(4, 32'h2);
      wreg(6, 32'h4);
      wreg(7, 32'h4);
      apb(1'b1, OFF_PSW, 32'(l) << PSW_L);
      n0 = mem_partner_inst.src_reads;
      run({24'h0, ENC_COPRO});
      check("cp reads", 32'(mem_partner_inst.src_reads - n0),
            32'(2 - l));
      check("cp write", 32'(peek(8'hA0)), 32'hBEEF);
      xreg(0, 32'h84, "cp src end");
      xreg(1, 32'hA4, "cp dst end");
      xreg(4, 32'h2, "cp incr");
      xreg(6, 32'h4, "cp swarp");
      xreg(7, 32'h4, "cp dwarp");
    end
    $display("test_copro done");
  endtask

  initial begin
    repeat (3) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    @(posedge CORE_CLK);
    test_map();
    test_pattern();
    test_word_or();
    test_bit_test();
    test_masked();
    test_desc();
    test_copro();
    complete_run();
  end
endmodule
`default_nettype wire

// ==== tb/mem_partner.sv ====
`default_nettype none
module mem_partner
  import gfx_pkg::*;
(
  // Clock, reset, answer speed
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  // Memory cycle from the block
  input wire logic req,
  input wire logic we,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] cycle,
  input wire logic copro,
  // Answer
  output logic [15:0] rdata,
  output logic ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:255];
  logic [15:0] copro_ctrl = 16'h0000;
  logic [7:0] a;
  int src_reads = 0;
  int waits = 0;
  assign a = addr[7:0];
  // Bus released: data toggles so stale values never match
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (!rstn) begin
      waits <= 0;
      rdata <= 16'h5A5A;
    end else if (req && !ack) begin
      if (waits < (slow ? 3 : 0)) begin
        waits <= waits + 1;
      end else begin
        waits <= 0;
        ack <= 1'b1;
        if (cycle == CYC_SRC_RD) begin
          src_reads <= src_reads + 1;
        end
        if (we) begin
          // Coprocessor supplies its own result on writes
          mem[a] <= copro ? copro_ctrl[7:0] : wdata[7:0];
          mem[a + 8'h01] <= copro ? copro_ctrl[15:8] : wdata[15:8];
        end else begin
          rdata <= {mem[a + 8'h01], mem[a]};
        end
      end
    end
  end
endmodule
`default_nettype wire
